// [tb/imush_host_model.sv]
/*
 Host side model: an SPI master driving both chip selects, clock and data in.
 Assumes the bench resolves the two serial outputs into one miso level.
*/
`timescale 1ns/1ps
module imush_host_model
(
   // Clock and returned data
   input wire logic clock,
   input wire logic miso,
   // Pins toward the device
   output logic accel_select_n,
   output logic gyro_select_n,
   output logic serial_clock,
   output logic serial_in
);
   // ****************************************
   // Frame engine
   // ****************************************
   initial
   begin
      accel_select_n = 1'b1;
      gyro_select_n = 1'b1;
      serial_clock = 1'b0;
      serial_in = 1'b0;
   end

   // Data in toggles between frames so no stale bit looks valid
   always @(negedge clock)
   begin
      if (accel_select_n && gyro_select_n)
         serial_in <= ~serial_in;
   end

   // Half of a 16-clock serial period
   task automatic half();
      repeat (8) @(negedge clock);
   endtask

   // One frame, bits sent from tx[23] down; received bits shift into rx
   task automatic xfer(input logic acc, input logic cpol, input logic [23:0] tx, input int nbits,
      output logic [23:0] rx);
      int i;
      rx = '0;
      serial_clock = cpol;
      @(negedge clock);
      accel_select_n = ~acc;
      gyro_select_n = acc;
      half();
      for (i = 0; i < nbits; i++)
      begin
         if (cpol || i > 0)
            serial_clock = 1'b0;
         serial_in = tx[23 - i];
         half();
         serial_clock = 1'b1;
         rx = {rx[22:0], miso};
         half();
      end
      if (!cpol)
         serial_clock = 1'b0;
      half();
      accel_select_n = 1'b1;
      gyro_select_n = 1'b1;
      half();
   endtask
endmodule // imush_host_model

// [tb/imush_serial_if_tb.sv]
/*
 Self-checking bench for the serial host interface.
 Assumes the host model file; the register store is a fixed pattern here.
*/
`timescale 1ns/1ps
module imush_serial_if_tb;
   // ****************************************
   // Signals and models
   // ****************************************
   logic clock, nrst, protocol_select_pin, accel_sdo_strap, gyro_sdo_strap, suspend_mode;
   logic accel_select_n, gyro_select_n, serial_clock, serial_in, miso;
   logic accel_serial_out, accel_serial_oe, gyro_serial_out, gyro_serial_oe;
   logic accel_spi_mode, gyro_spi_mode, accel_addr_lsb, gyro_addr_lsb, spi_cpol;
   logic [7:0] rd_data, wr_data;
   logic [6:0] rd_addr, wr_addr;
   logic rd_req, rd_accel, wr_strobe, wr_accel, write_busy, a_oe_seen, g_oe_seen;
   logic [23:0] rx;
   int num_errors = 0;
   int comparisons = 0;
   int strobes, busy_cnt, reqs;

   // Shared output line as the host sees it
   assign miso = accel_serial_oe ? accel_serial_out : (gyro_serial_oe ? gyro_serial_out : 1'bz);
   assign rd_data = {rd_accel, rd_addr} ^ 8'h3C;

   imush_host_model host (.clock(clock), .miso(miso), .accel_select_n(accel_select_n),
      .gyro_select_n(gyro_select_n), .serial_clock(serial_clock), .serial_in(serial_in));

   imush_serial_if #(.IDLE_SUSPEND_CYC(50)) DUT (.clock(clock), .nrst(nrst),
      .protocol_select_pin(protocol_select_pin), .accel_select_n(accel_select_n),
      .gyro_select_n(gyro_select_n), .serial_clock(serial_clock), .serial_in(serial_in),
      .accel_sdo_strap(accel_sdo_strap), .gyro_sdo_strap(gyro_sdo_strap),
      .accel_serial_out(accel_serial_out), .accel_serial_oe(accel_serial_oe),
      .gyro_serial_out(gyro_serial_out), .gyro_serial_oe(gyro_serial_oe),
      .accel_spi_mode(accel_spi_mode), .gyro_spi_mode(gyro_spi_mode), .accel_addr_lsb(accel_addr_lsb),
      .gyro_addr_lsb(gyro_addr_lsb), .spi_cpol(spi_cpol), .suspend_mode(suspend_mode), .rd_data(rd_data),
      .rd_addr(rd_addr), .rd_req(rd_req), .rd_accel(rd_accel), .wr_strobe(wr_strobe), .wr_accel(wr_accel),
      .wr_addr(wr_addr), .wr_data(wr_data), .write_busy(write_busy));

   // Clock
   initial
   begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   // Activity monitors, cleared by the scenarios
   always @(posedge clock)
   begin
      if (accel_serial_oe)
         a_oe_seen <= 1'b1;
      if (gyro_serial_oe)
         g_oe_seen <= 1'b1;
      if (wr_strobe)
         strobes <= strobes + 1;
      if (write_busy)
         busy_cnt <= busy_cnt + 1;
      if (rd_req)
         reqs <= reqs + 1;
   end

   // ****************************************
   // Checking and scenarios
   // ****************************************
   task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   function automatic logic [7:0] reg_val(input logic acc, input logic [6:0] a);
      return {acc, a} ^ 8'h3C;
   endfunction

   task automatic t_start();
      check("accel mode", accel_spi_mode, 24'h0);
      check("gyro mode", gyro_spi_mode, 24'h1);
      check("lsbs", {accel_addr_lsb, gyro_addr_lsb}, 24'h2);
      check("oe idle", {accel_serial_oe, gyro_serial_oe}, 24'h0);
   endtask

   // Throwaway ident read: refused, yet switches accel to SPI
   task automatic t_accel_wake();
      a_oe_seen = 1'b0;
      host.xfer(1'b1, 1'b0, 24'h800000, 16, rx);
      repeat (4) @(negedge clock);
      check("accel refused", a_oe_seen, 24'h0);
      check("accel mode", accel_spi_mode, 24'h1);
   endtask

   // Gyro burst of two bytes, no filler; cpol picks the mode
   task automatic t_gyro_burst(input logic cpol);
      reqs = 0;
      host.xfer(1'b0, cpol, {1'b1, 7'h12, 16'h0}, 24, rx);
      check("fetches", reqs, 24'h3);
      check("gyro byte0", rx[15:8], reg_val(1'b0, 7'h12));
      check("gyro byte1", rx[7:0], reg_val(1'b0, 7'h13));
      check("cpol", spi_cpol, cpol);
      check("gyro oe", gyro_serial_oe, 24'h0);
   endtask

   task automatic t_accel_read();
      host.xfer(1'b1, 1'b0, {1'b1, 7'h05, 16'h0}, 24, rx);
      check("filler", rx[15:8], 24'h0);
      check("accel data", rx[7:0], reg_val(1'b1, 7'h05));
      check("accel oe", accel_serial_oe, 24'h0);
   endtask

   // Write, then measure the idle time reported after it
   task automatic t_write(input logic acc, input logic susp, input int exp_busy);
      suspend_mode = susp;
      strobes = 0;
      busy_cnt = 0;
      host.xfer(acc, 1'b1, {1'b0, 7'h33, 8'hA5, 8'h00}, 16, rx);
      repeat (exp_busy + 20) @(negedge clock);
      check("strobes", strobes, 24'h1);
      check("write", {wr_accel, wr_addr, wr_data}, {acc, 7'h33, 8'hA5});
      check("idle", (busy_cnt >= exp_busy) && (busy_cnt <= exp_busy + 4), 24'h1);
   endtask

   // Two-wire select: gyro drops out, accel keeps SPI
   task automatic t_two_wire();
      protocol_select_pin = 1'b1;
      repeat (4) @(negedge clock);
      check("gyro mode", gyro_spi_mode, 24'h0);
      g_oe_seen = 1'b0;
      host.xfer(1'b0, 1'b0, 24'h920000, 16, rx);
      check("gyro refused", g_oe_seen, 24'h0);
      check("accel kept", accel_spi_mode, 24'h1);
      protocol_select_pin = 1'b0;
      repeat (4) @(negedge clock);
      check("gyro back", gyro_spi_mode, 24'h1);
   endtask

   task automatic complete_run();
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Watchdog well beyond the ~22 us of traffic
   initial
   begin
      #200000;
      num_errors++;
      complete_run();
   end

   // Main sequence
   initial
   begin
      nrst = 1'b0;
      protocol_select_pin = 1'b0;
      accel_sdo_strap = 1'b1;
      gyro_sdo_strap = 1'b0;
      suspend_mode = 1'b0;
      repeat (4) @(negedge clock);
      nrst = 1'b1;
      repeat (6) @(negedge clock);
      t_start();
      t_accel_wake();
      t_gyro_burst(1'b0);
      t_gyro_burst(1'b1);
      t_accel_read();
      t_write(1'b0, 1'b0, 250);
      t_write(1'b1, 1'b1, 50);
      t_two_wire();
      complete_run();
   end
endmodule // imush_serial_if_tb

// [verilog/imush_defines.svh]
/*
 Timing constants and fixed values for the serial host interface block.
 Included by the serial interface module only; definitions only.
*/
`ifndef IMUSH_DEFINES_SVH
`define IMUSH_DEFINES_SVH
// Write idle times in ns (2 us normal, 1000 us suspend)
`define IMUSH_IDLE_NORMAL_NS 2000
`define IMUSH_IDLE_SUSPEND_NS 1000000
`define IMUSH_CLK_NS 8
`define IMUSH_CMD_BITS 8
`define IMUSH_ADDR_BITS 7
`define IMUSH_DATA_BITS 8
`define IMUSH_ADDR_TOP 7'h7F
`endif

// [verilog/imush_pkg.sv]
/*
 Types shared by the serial host interface block.
 Assumes the defines header is compiled alongside.
*/
package imush_pkg;
   // Phase of one serial frame, Gray coded along the accel read path
   typedef enum logic [1:0]
   {
      IMUSH_IDLE = 2'b00,
      IMUSH_CMD = 2'b01,
      IMUSH_DUMMY = 2'b11,
      IMUSH_DATA = 2'b10
   } imush_phase_t;
endpackage

// [verilog/imush_serial_if.sv]
/*
 Serial slave interface of a two-part motion sensor: protocol select, accel
 start-up in two-wire mode, SPI frames with burst read, dummy byte on accel.
 Assumes all pin inputs are asynchronous; they pass two flip-flops here.
 Register storage sits outside: reads fetch rd_data for rd_addr.
*/
// Notes on behaviour
// - Protocol select high means two-wire mode, low means SPI.
// - In two-wire mode each serial output level sets its address LSB.
// - Gyro part takes its protocol directly from the select pin.
// - Accel starts in two-wire mode, SPI after chip select rise, until reset.
// - Accel read sends one filler byte before register data.
// - Gyro read sends data right after the address.
// - Modes 00 and 11 accepted, chosen from clock level after select falls.
// - Single write or gyro read is one 16-bit frame, command then data; accel read adds the filler byte.
// - Frame spans select low; master alone drives clock.
// - Data changes on falling clock, sampled on rising clock.
// - First frame bit is direction, 1 means read.
// - Bits 1 to 7 are address, MSB first.
// - Bits 8 to 15 carry write data or gyro read data.
// - Burst read advances address each byte while select low.
`timescale 1ns/1ps
`include "imush_defines.svh"
module imush_serial_if
   import imush_pkg::*;
#(
   parameter int IDLE_SUSPEND_CYC = (`IMUSH_IDLE_SUSPEND_NS + `IMUSH_CLK_NS - 1) / `IMUSH_CLK_NS
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Pins
   input wire logic protocol_select_pin,
   input wire logic accel_select_n,
   input wire logic gyro_select_n,
   input wire logic serial_clock,
   input wire logic serial_in,
   input wire logic accel_sdo_strap,
   input wire logic gyro_sdo_strap,
   output logic accel_serial_out,
   output logic accel_serial_oe,
   output logic gyro_serial_out,
   output logic gyro_serial_oe,
   // Mode status
   output logic accel_spi_mode,
   output logic gyro_spi_mode,
   output logic accel_addr_lsb,
   output logic gyro_addr_lsb,
   output logic spi_cpol,
   // Register side
   input wire logic suspend_mode,
   input wire logic [7:0] rd_data,
   output logic [6:0] rd_addr,
   output logic rd_req,
   output logic rd_accel,
   output logic wr_strobe,
   output logic wr_accel,
   output logic [6:0] wr_addr,
   output logic [7:0] wr_data,
   output logic write_busy
);
   localparam int IDLE_NORMAL_CYC = (`IMUSH_IDLE_NORMAL_NS + `IMUSH_CLK_NS - 1) / `IMUSH_CLK_NS;
   // ************************************************************
   // Synchronisers
   // ************************************************************
   logic [7:0] sync1;
   logic [7:0] sync2;
   logic [7:0] sync3;
   // First stage is read only by the second
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         sync1 <= 8'hF8; // Marker bit 2 resets low to time the strap capture
         sync2 <= 8'hF8;
         sync3 <= 8'hF8;
      end
      else
      begin
         sync1 <= {protocol_select_pin, accel_select_n, gyro_select_n, serial_clock, serial_in, 1'b1,
            accel_sdo_strap, gyro_sdo_strap};
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end
   wire proto_s = sync2[7];
   wire acs_s = sync2[6];
   wire gcs_s = sync2[5];
   wire sck_s = sync2[4];
   wire din_s = sync2[3];
   wire sck_rise = sck_s && !sync3[4];
   wire sck_fall = !sck_s && sync3[4];
   wire acs_rise = acs_s && !sync3[6];
   wire acs_fall = !acs_s && sync3[6];
   wire gcs_fall = !gcs_s && sync3[5];
   wire cs_fall = acs_fall || gcs_fall;
   // ************************************************************
   // Protocol selection
   // ************************************************************
   wire gyro_spi = !proto_s;
   // Accel SPI sticky until power-up reset; clock level at select fall picks the mode
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         accel_spi_mode <= 1'b0;
         gyro_spi_mode <= 1'b0;
         spi_cpol <= 1'b0;
      end
      else
      begin
         accel_spi_mode <= accel_spi_mode || acs_rise;
         gyro_spi_mode <= gyro_spi;
         if (cs_fall)
            spi_cpol <= sck_s;
      end
   end
   logic strap_done;
   // Straps caught after reset release, not in the reset branch
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         strap_done <= 1'b0;
         accel_addr_lsb <= 1'b0;
         gyro_addr_lsb <= 1'b0;
      end
      else if (!strap_done && sync3[2])
      begin
         strap_done <= 1'b1;
         accel_addr_lsb <= sync2[1];
         gyro_addr_lsb <= sync2[0];
      end
   end
   // ************************************************************
   // Frame engine
   // ************************************************************
   imush_phase_t phase;
   logic is_accel;
   logic is_read;
   logic [2:0] bitcnt;
   logic [7:0] shreg;
   logic [7:0] txreg;
   logic [6:0] addr;
   wire sel_low = is_accel ? !acs_s : !gcs_s;
   // Accel frames only decode once in SPI; gyro only when pin says SPI
   wire frame_ok = is_accel ? accel_spi_mode : gyro_spi;
   wire byte_end = sck_rise && (bitcnt == 3'h7);
   wire [7:0] shnext = {shreg[6:0], din_s};
   wire [6:0] addr_inc = addr + 7'h01;
   wire out_phase = (phase == IMUSH_DUMMY) || (phase == IMUSH_DATA); // Stale read state never drives at frame start
   // Main sequencer
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         phase <= IMUSH_IDLE;
         is_accel <= 1'b0;
         is_read <= 1'b0;
         bitcnt <= 3'h0;
         shreg <= 8'h00;
         addr <= 7'h00;
         rd_req <= 1'b0;
         wr_strobe <= 1'b0;
         wr_addr <= 7'h00;
         wr_data <= 8'h00;
      end
      else
      begin
         rd_req <= 1'b0;
         wr_strobe <= 1'b0;
         if (phase == IMUSH_IDLE)
         begin
            bitcnt <= 3'h0;
            if (acs_fall || gcs_fall)
            begin
               phase <= IMUSH_CMD;
               is_accel <= acs_fall;
            end
         end
         else if (!sel_low)
            phase <= IMUSH_IDLE;
         else if (sck_rise)
         begin
            shreg <= shnext;
            bitcnt <= bitcnt + 3'h1;
            if (byte_end && frame_ok)
            begin
               case (phase)
                  IMUSH_CMD:
                  begin
                     is_read <= shnext[7];
                     addr <= shnext[6:0];
                     if (shnext[7])
                     begin
                        rd_req <= 1'b1;
                        phase <= is_accel ? IMUSH_DUMMY : IMUSH_DATA;
                     end
                     else
                        phase <= IMUSH_DATA;
                  end
                  IMUSH_DUMMY:
                     phase <= IMUSH_DATA;
                  IMUSH_DATA:
                  begin
                     if (is_read)
                     begin
                        addr <= addr_inc;
                        rd_req <= 1'b1;
                     end
                     else
                     begin
                        wr_strobe <= 1'b1;
                        wr_addr <= addr;
                        wr_data <= shnext;
                     end
                  end
                  default:
                     phase <= IMUSH_IDLE;
               endcase
            end
         end
      end
   end
   // Read address for next data byte; burst reads fetch after increment
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         rd_addr <= 7'h00;
         rd_accel <= 1'b0;
         wr_accel <= 1'b0;
      end
      else
      begin
         rd_addr <= (phase == IMUSH_DATA && is_read) ? addr : shreg[6:0];
         rd_accel <= is_accel;
         wr_accel <= is_accel;
      end
   end
   // ************************************************************
   // Output shifter
   // ************************************************************
   // Load on byte boundary at first falling edge; filler byte sends zeros
   logic load_pend;
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         txreg <= 8'h00;
         load_pend <= 1'b0;
      end
      else if (byte_end)
         load_pend <= 1'b1;
      else if (sck_fall)
      begin
         load_pend <= 1'b0;
         if (load_pend)
            txreg <= (phase == IMUSH_DATA && is_read) ? rd_data : 8'h00;
         else
            txreg <= {txreg[6:0], 1'b0};
      end
   end
   wire drive_a = accel_spi_mode && !acs_s && is_accel && is_read && out_phase;
   wire drive_g = gyro_spi && !gcs_s && !is_accel && is_read && out_phase;
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         accel_serial_out <= 1'b0;
         accel_serial_oe <= 1'b0;
         gyro_serial_out <= 1'b0;
         gyro_serial_oe <= 1'b0;
      end
      else
      begin
         accel_serial_out <= txreg[7];
         gyro_serial_out <= txreg[7];
         accel_serial_oe <= drive_a;
         gyro_serial_oe <= drive_g;
      end
   end
   // ************************************************************
   // Write idle timer
   // ************************************************************
   logic [19:0] idle_cnt;
   // Holds write_busy high for the idle time after each write
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         idle_cnt <= 20'h00000;
      else if (wr_strobe)
         idle_cnt <= suspend_mode ? 20'(IDLE_SUSPEND_CYC) : 20'(IDLE_NORMAL_CYC);
      else if (idle_cnt != 20'h00000)
         idle_cnt <= idle_cnt - 20'h00001;
   end
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         write_busy <= 1'b0;
      else
         write_busy <= (idle_cnt > 20'h00001) || wr_strobe;
   end
   // ************************************************************
   // Checks
   // ************************************************************
   AST_OE_RELEASE: assert property (@(posedge clock) disable iff (!nrst)
      acs_s |=> !accel_serial_oe) else $error("accel output driven while deselected");
   AST_GYRO_RELEASE: assert property (@(posedge clock) disable iff (!nrst)
      gcs_s |=> !gyro_serial_oe) else $error("gyro output driven while deselected");
   AST_ACCEL_STICKY: assert property (@(posedge clock) disable iff (!nrst)
      accel_spi_mode |=> accel_spi_mode) else $error("accel left SPI mode");
   AST_ACCEL_ENTRY: assert property (@(posedge clock) disable iff (!nrst)
      acs_rise |=> accel_spi_mode) else $error("accel missed SPI entry");
   AST_GYRO_PROTO: assert property (@(posedge clock) disable iff (!nrst)
      proto_s |=> !gyro_spi_mode) else $error("gyro mode not following select pin");
   AST_ACCEL_DUMMY: assert property (@(posedge clock) disable iff (!nrst)
      (phase == IMUSH_CMD && byte_end && sel_low && frame_ok && is_accel && shnext[7]) |=> phase == IMUSH_DUMMY)
      else $error("accel read skipped filler byte");
   AST_GYRO_NODUMMY: assert property (@(posedge clock) disable iff (!nrst)
      (phase == IMUSH_CMD && byte_end && sel_low && frame_ok && !is_accel) |=> phase == IMUSH_DATA)
      else $error("gyro entered filler phase");
   AST_BURST_INC: assert property (@(posedge clock) disable iff (!nrst)
      (phase == IMUSH_DATA && is_read && byte_end && sel_low && frame_ok) |=> addr == $past(addr) + 7'h01)
      else $error("burst address not advanced");
   AST_CPOL: assert property (@(posedge clock) disable iff (!nrst)
      cs_fall |=> spi_cpol == $past(sck_s)) else $error("mode not taken from clock level");
   AST_WRITE_IDLE: assert property (@(posedge clock) disable iff (!nrst)
      (wr_strobe && !suspend_mode) |=> write_busy [*8]) else $error("write idle too short");
endmodule // imush_serial_if
